// [olc_layer_config.sv]
// overlay layer configuration registers, pixel colour path and fetch address walker
//
// Summary of operation
// - palette bit selects direct colour or index
// - format codes 0..8 decode low-depth formats
// - format codes 9..13 decode deep formats
// - palette depth codes give 1,2,4,8 bits
// - window left edge from position bits 10:0
// - window top edge from position bits 26:16
// - window width is size field plus one
// - window height is size field plus one
// - next row adds row stride bytes
// - next pixel adds pixel stride bytes
// - default colour held in rgb byte fields
// - key colour held in rgb byte fields
// - key compare only masked-in bits
// - key match only when enabled
// - fetch off selects default colour
// - narrow components shifted, zero or msb filled
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module olc_layer_config #(
   parameter int PAL_ENTRIES = 256
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic pix_in_valid,
   input wire logic [31:0] pix_in_word,
   output logic pix_out_valid,
   output logic [23:0] pix_out_rgb,
   output logic pix_out_key_match,
   input wire logic frame_start,
   input wire logic pixel_advance,
   input wire logic [31:0] base_addr,
   output logic [31:0] fetch_addr,
   output logic fetch_busy,
   output logic palette_mode,
   output logic [5:0] bits_per_pixel,
   output logic [10:0] window_left,
   output logic [10:0] window_top,
   output logic [11:0] window_width,
   output logic [11:0] window_height
);

   typedef enum logic [1:0] {
      OLC_IDLE = 2'b00,
      OLC_RUN = 2'b01,
      OLC_LAST = 2'b11
   } olc_walk_t;

   typedef struct packed {
      logic [31:0] fmt;
      logic [31:0] pos;
      logic [31:0] size;
      logic [31:0] row_stride;
      logic [31:0] pixel_stride;
      logic [31:0] def_colour;
      logic [31:0] key_colour;
      logic [31:0] key_mask;
      logic [31:0] blend;
      logic [7:0] pal_index;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic out_valid;
      logic [23:0] out_rgb;
      logic out_key;
      olc_walk_t walk;
      logic [31:0] fetch_addr;
      logic [31:0] row_start;
      logic [11:0] col;
      logic [11:0] row;
      logic busy;
      logic palette_mode;
      logic [5:0] bpp;
      logic [10:0] left;
      logic [10:0] top;
      logic [11:0] width;
      logic [11:0] height;
   } olc_state_t;

   olc_state_t st_q;
   olc_state_t st_d;

   // bits per pixel of a direct colour format
   function automatic logic [5:0] fmt_bpp(input logic [3:0] f);
      case (f)
         olc_pkg::OLC_FMT_RGB444: fmt_bpp = 6'h0C;
         olc_pkg::OLC_FMT_ARGB4444, olc_pkg::OLC_FMT_RGBA4444,
         olc_pkg::OLC_FMT_RGB565, olc_pkg::OLC_FMT_TRGB1555: fmt_bpp = 6'h10;
         olc_pkg::OLC_FMT_RGB666, olc_pkg::OLC_FMT_RGB666_PACKED: fmt_bpp = 6'h12;
         olc_pkg::OLC_FMT_TRGB1666, olc_pkg::OLC_FMT_TRGB1666_PACKED: fmt_bpp = 6'h13;
         olc_pkg::OLC_FMT_RGB888, olc_pkg::OLC_FMT_RGB888_PACKED: fmt_bpp = 6'h18;
         olc_pkg::OLC_FMT_TRGB1888: fmt_bpp = 6'h19;
         olc_pkg::OLC_FMT_ARGB8888, olc_pkg::OLC_FMT_RGBA8888: fmt_bpp = 6'h20;
         default: fmt_bpp = 6'h00;
      endcase
   endfunction : fmt_bpp

   // bits per pixel of a palette depth code
   function automatic logic [5:0] pal_bpp(input logic [1:0] d);
      case (d)
         olc_pkg::OLC_DEPTH_1: pal_bpp = 6'h01;
         olc_pkg::OLC_DEPTH_2: pal_bpp = 6'h02;
         olc_pkg::OLC_DEPTH_4: pal_bpp = 6'h04;
         default: pal_bpp = 6'h08;
      endcase
   endfunction : pal_bpp

   // index mask of a palette depth code
   function automatic logic [7:0] pal_mask(input logic [1:0] d);
      case (d)
         olc_pkg::OLC_DEPTH_1: pal_mask = 8'h01;
         olc_pkg::OLC_DEPTH_2: pal_mask = 8'h03;
         olc_pkg::OLC_DEPTH_4: pal_mask = 8'h0F;
         default: pal_mask = 8'hFF;
      endcase
   endfunction : pal_mask

   // register read decode, top bit flags a mapped address
   function automatic logic [32:0] reg_value(input olc_state_t s, input logic [31:0] a, input logic [23:0] pal);
      case (a)
         olc_pkg::OLC_ADDR_FORMAT: reg_value = {1'b1, s.fmt};
         olc_pkg::OLC_ADDR_POSITION: reg_value = {1'b1, s.pos};
         olc_pkg::OLC_ADDR_SIZE: reg_value = {1'b1, s.size};
         olc_pkg::OLC_ADDR_ROW_STRIDE: reg_value = {1'b1, s.row_stride};
         olc_pkg::OLC_ADDR_PIX_STRIDE: reg_value = {1'b1, s.pixel_stride};
         olc_pkg::OLC_ADDR_DEFAULT: reg_value = {1'b1, s.def_colour};
         olc_pkg::OLC_ADDR_KEY: reg_value = {1'b1, s.key_colour};
         olc_pkg::OLC_ADDR_KEY_MASK: reg_value = {1'b1, s.key_mask};
         olc_pkg::OLC_ADDR_BLEND: reg_value = {1'b1, s.blend};
         olc_pkg::OLC_ADDR_PAL_INDEX: reg_value = {1'b1, 24'h000000, s.pal_index};
         olc_pkg::OLC_ADDR_PAL_DATA: reg_value = {1'b1, 8'h00, pal};
         default: reg_value = {1'b0, olc_pkg::OLC_RESET_WORD};
      endcase
   endfunction : reg_value

   logic [23:0] pal_mem [PAL_ENTRIES];
   logic wr_acc;
   logic pal_we;
   logic [23:0] pal_rd;
   logic [7:0] pal_idx;
   logic [23:0] pal_pix;
   logic [23:0] direct_rgb;
   logic [32:0] rd_word;
   logic [23:0] colour;
   logic fetch_en;
   logic key_en;
   logic row_end;
   logic frame_end;

   // write takes effect at the access edge only
   assign wr_acc = psel && penable && st_q.pready && pwrite;
   assign pal_we = wr_acc && (paddr == olc_pkg::OLC_ADDR_PAL_DATA);
   assign pal_rd = pal_mem[st_q.pal_index];
   assign pal_idx = pix_in_word[7:0] & pal_mask(st_q.fmt[olc_pkg::OLC_DEPTH_LSB +: 2]);
   assign pal_pix = pal_mem[pal_idx];
   assign fetch_en = st_q.blend[olc_pkg::OLC_FETCH_ENABLE_BIT];
   assign key_en = st_q.blend[olc_pkg::OLC_KEY_ENABLE_BIT];
   assign row_end = st_q.col == {1'b0, st_q.size[olc_pkg::OLC_H_LSB +: olc_pkg::OLC_COORD_W]};
   assign frame_end = st_q.row == {1'b0, st_q.size[olc_pkg::OLC_V_LSB +: olc_pkg::OLC_COORD_W]};

   // direct colour widening
   olc_pixel_expand u_expand (
      .format(st_q.fmt[olc_pkg::OLC_FORMAT_LSB +: 4]),
      .pixel(pix_in_word),
      .replicate(st_q.blend[olc_pkg::OLC_REPLICATE_BIT]),
      .rgb(direct_rgb)
   );

   // palette storage, loaded through the palette data register
   always_ff @(posedge core_clk)
   begin
      if (clk_en && pal_we)
         pal_mem[st_q.pal_index] <= pwdata[23:0];
   end

   // next state of registers, bus answer, pixel path and address walker
   always_comb
   begin
      st_d = st_q;
      rd_word = reg_value(st_q, paddr, pal_rd);
      colour = 24'h000000;
      // answer one cycle after setup, zero wait
      st_d.pready = psel && !penable;
      if (psel && !penable)
      begin
         st_d.prdata = pwrite ? olc_pkg::OLC_RESET_WORD : rd_word[31:0];
         st_d.pslverr = !rd_word[32];
      end
      // register writes, reserved bits dropped
      if (wr_acc)
      begin
         case (paddr)
            olc_pkg::OLC_ADDR_FORMAT: st_d.fmt = pwdata & olc_pkg::OLC_MASK_FORMAT;
            olc_pkg::OLC_ADDR_POSITION: st_d.pos = pwdata & olc_pkg::OLC_MASK_COORD;
            olc_pkg::OLC_ADDR_SIZE: st_d.size = pwdata & olc_pkg::OLC_MASK_COORD;
            olc_pkg::OLC_ADDR_ROW_STRIDE: st_d.row_stride = pwdata & olc_pkg::OLC_MASK_WORD;
            olc_pkg::OLC_ADDR_PIX_STRIDE: st_d.pixel_stride = pwdata & olc_pkg::OLC_MASK_WORD;
            olc_pkg::OLC_ADDR_DEFAULT: st_d.def_colour = pwdata & olc_pkg::OLC_MASK_COLOUR;
            olc_pkg::OLC_ADDR_KEY: st_d.key_colour = pwdata & olc_pkg::OLC_MASK_COLOUR;
            olc_pkg::OLC_ADDR_KEY_MASK: st_d.key_mask = pwdata & olc_pkg::OLC_MASK_COLOUR;
            olc_pkg::OLC_ADDR_BLEND: st_d.blend = pwdata & olc_pkg::OLC_MASK_BLEND;
            olc_pkg::OLC_ADDR_PAL_INDEX: st_d.pal_index = pwdata[7:0];
            olc_pkg::OLC_ADDR_PAL_DATA: st_d.pal_index = st_q.pal_index + 8'h01;
            default: st_d.pslverr = st_q.pslverr;
         endcase
      end
      // geometry and depth seen by the rest of the controller
      st_d.palette_mode = st_d.fmt[olc_pkg::OLC_PALETTE_ENABLE_BIT];
      st_d.bpp = st_d.palette_mode ? pal_bpp(st_d.fmt[olc_pkg::OLC_DEPTH_LSB +: 2]) :
         fmt_bpp(st_d.fmt[olc_pkg::OLC_FORMAT_LSB +: 4]);
      st_d.left = st_d.pos[olc_pkg::OLC_H_LSB +: olc_pkg::OLC_COORD_W];
      st_d.top = st_d.pos[olc_pkg::OLC_V_LSB +: olc_pkg::OLC_COORD_W];
      st_d.width = {1'b0, st_d.size[olc_pkg::OLC_H_LSB +: olc_pkg::OLC_COORD_W]} + 12'h001;
      st_d.height = {1'b0, st_d.size[olc_pkg::OLC_V_LSB +: olc_pkg::OLC_COORD_W]} + 12'h001;
      // pixel colour and chroma key
      st_d.out_valid = pix_in_valid;
      if (pix_in_valid)
      begin
         if (!fetch_en)
            colour = st_q.def_colour[23:0];
         else if (st_q.fmt[olc_pkg::OLC_PALETTE_ENABLE_BIT])
            colour = pal_pix;
         else
            colour = direct_rgb;
         st_d.out_rgb = colour;
         st_d.out_key = key_en && (((colour ^ st_q.key_colour[23:0]) & st_q.key_mask[23:0]) == 24'h000000);
      end
      // fetch address walker
      case (st_q.walk)
         OLC_IDLE:
         begin
            if (frame_start)
            begin
               st_d.walk = OLC_RUN;
               st_d.fetch_addr = base_addr;
               st_d.row_start = base_addr;
               st_d.col = 12'h000;
               st_d.row = 12'h000;
            end
         end
         OLC_RUN:
         begin
            if (pixel_advance)
            begin
               if (!row_end)
               begin
                  st_d.fetch_addr = st_q.fetch_addr + st_q.pixel_stride;
                  st_d.col = st_q.col + 12'h001;
               end
               else if (!frame_end)
               begin
                  st_d.row_start = st_q.row_start + st_q.row_stride;
                  st_d.fetch_addr = st_q.row_start + st_q.row_stride;
                  st_d.col = 12'h000;
                  st_d.row = st_q.row + 12'h001;
               end
               else
                  st_d.walk = OLC_LAST;
            end
         end
         OLC_LAST: st_d.walk = OLC_IDLE;
         default: st_d.walk = OLC_IDLE;
      endcase
      st_d.busy = st_d.walk != OLC_IDLE;
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         // format code 0 is 12 bpp direct and size 0 is one pixel, shown from reset on
         st_q <= '0;
         st_q.bpp <= fmt_bpp(olc_pkg::OLC_FMT_RGB444);
         st_q.width <= 12'h001;
         st_q.height <= 12'h001;
      end
      else if (clk_en)
         st_q <= st_d;
   end

   // outputs straight from the state register
   assign pready = st_q.pready;
   assign prdata = st_q.prdata;
   assign pslverr = st_q.pslverr;
   assign pix_out_valid = st_q.out_valid;
   assign pix_out_rgb = st_q.out_rgb;
   assign pix_out_key_match = st_q.out_key;
   assign fetch_addr = st_q.fetch_addr;
   assign fetch_busy = st_q.busy;
   assign palette_mode = st_q.palette_mode;
   assign bits_per_pixel = st_q.bpp;
   assign window_left = st_q.left;
   assign window_top = st_q.top;
   assign window_width = st_q.width;
   assign window_height = st_q.height;

   // checks
   default clocking olc_cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   chk_width_plus_one: assert property (
      clk_en && wr_acc && paddr == olc_pkg::OLC_ADDR_SIZE
      |=> window_width == {1'b0, $past(pwdata[olc_pkg::OLC_H_LSB +: olc_pkg::OLC_COORD_W])} + 12'h001)
      else $error("window width not size plus one");
   chk_height_plus_one: assert property (
      clk_en && wr_acc && paddr == olc_pkg::OLC_ADDR_SIZE
      |=> window_height == {1'b0, $past(pwdata[olc_pkg::OLC_V_LSB +: olc_pkg::OLC_COORD_W])} + 12'h001)
      else $error("window height not size plus one");
   chk_window_edges: assert property (
      clk_en && wr_acc && paddr == olc_pkg::OLC_ADDR_POSITION
      |=> window_left == $past(pwdata[olc_pkg::OLC_H_LSB +: olc_pkg::OLC_COORD_W])
      && window_top == $past(pwdata[olc_pkg::OLC_V_LSB +: olc_pkg::OLC_COORD_W]))
      else $error("window position not taken from write");
   chk_default_colour: assert property (
      clk_en && pix_in_valid && !fetch_en
      |=> pix_out_valid && pix_out_rgb == $past(st_q.def_colour[23:0]))
      else $error("default colour not used with fetch off");
   chk_palette_lookup: assert property (
      clk_en && pix_in_valid && fetch_en && st_q.fmt[olc_pkg::OLC_PALETTE_ENABLE_BIT]
      |=> pix_out_rgb == $past(pal_pix))
      else $error("palette entry not used for index");
   chk_key_disabled: assert property (
      clk_en && pix_in_valid && !key_en |=> !pix_out_key_match)
      else $error("key match while disabled");
   chk_key_mask_open: assert property (
      clk_en && pix_in_valid && key_en && st_q.key_mask[23:0] == 24'h000000 |=> pix_out_key_match)
      else $error("empty key mask did not match");
   chk_pixel_stride: assert property (
      clk_en && st_q.walk == OLC_RUN && pixel_advance && !row_end
      |=> fetch_addr == $past(st_q.fetch_addr) + $past(st_q.pixel_stride))
      else $error("pixel step not pixel stride");
   chk_row_stride: assert property (
      clk_en && st_q.walk == OLC_RUN && pixel_advance && row_end && !frame_end
      |=> fetch_addr == $past(st_q.row_start) + $past(st_q.row_stride))
      else $error("row step not row stride");
   chk_reserved_zero: assert property (
      clk_en && psel && !penable && !pwrite && paddr == olc_pkg::OLC_ADDR_FORMAT
      |=> pready && (prdata & ~olc_pkg::OLC_MASK_FORMAT) == 32'h00000000)
      else $error("reserved format bits read nonzero");
   chk_palette_depth: assert property (
      palette_mode |-> bits_per_pixel == pal_bpp(st_q.fmt[olc_pkg::OLC_DEPTH_LSB +: 2]))
      else $error("palette depth wrong");
   chk_direct_depth: assert property (
      !palette_mode |-> bits_per_pixel == fmt_bpp(st_q.fmt[olc_pkg::OLC_FORMAT_LSB +: 4]))
      else $error("direct format depth wrong");

endmodule : olc_layer_config
`default_nettype wire

// [olc_pkg.sv]
// shared constants for the overlay layer configuration block
package olc_pkg;

   // register byte addresses
   localparam logic [31:0] OLC_ADDR_FORMAT = 32'hF8038130;
   localparam logic [31:0] OLC_ADDR_POSITION = 32'hF8038134;
   localparam logic [31:0] OLC_ADDR_SIZE = 32'hF8038138;
   localparam logic [31:0] OLC_ADDR_ROW_STRIDE = 32'hF803813C;
   localparam logic [31:0] OLC_ADDR_PIX_STRIDE = 32'hF8038140;
   localparam logic [31:0] OLC_ADDR_DEFAULT = 32'hF8038144;
   localparam logic [31:0] OLC_ADDR_KEY = 32'hF8038148;
   localparam logic [31:0] OLC_ADDR_KEY_MASK = 32'hF803814C;
   localparam logic [31:0] OLC_ADDR_BLEND = 32'hF8038150;
   localparam logic [31:0] OLC_ADDR_PAL_INDEX = 32'hF8038160;
   localparam logic [31:0] OLC_ADDR_PAL_DATA = 32'hF8038164;

   // writable bits per register, all others reserved
   localparam logic [31:0] OLC_MASK_FORMAT = 32'h000003F1;
   localparam logic [31:0] OLC_MASK_COORD = 32'h07FF07FF;
   localparam logic [31:0] OLC_MASK_WORD = 32'hFFFFFFFF;
   localparam logic [31:0] OLC_MASK_COLOUR = 32'h00FFFFFF;
   localparam logic [31:0] OLC_MASK_BLEND = 32'h00000301;
   localparam logic [31:0] OLC_MASK_PAL_INDEX = 32'h000000FF;
   localparam logic [31:0] OLC_RESET_WORD = 32'h00000000;

   // field positions
   localparam int OLC_PALETTE_ENABLE_BIT = 0;
   localparam int OLC_FORMAT_LSB = 4;
   localparam int OLC_DEPTH_LSB = 8;
   localparam int OLC_H_LSB = 0;
   localparam int OLC_V_LSB = 16;
   localparam int OLC_COORD_W = 11;
   localparam int OLC_KEY_ENABLE_BIT = 0;
   localparam int OLC_FETCH_ENABLE_BIT = 8;
   localparam int OLC_REPLICATE_BIT = 9;
   localparam int OLC_PAL_INDEX_W = 8;

   // direct colour format codes
   localparam logic [3:0] OLC_FMT_RGB444 = 4'h0;
   localparam logic [3:0] OLC_FMT_ARGB4444 = 4'h1;
   localparam logic [3:0] OLC_FMT_RGBA4444 = 4'h2;
   localparam logic [3:0] OLC_FMT_RGB565 = 4'h3;
   localparam logic [3:0] OLC_FMT_TRGB1555 = 4'h4;
   localparam logic [3:0] OLC_FMT_RGB666 = 4'h5;
   localparam logic [3:0] OLC_FMT_RGB666_PACKED = 4'h6;
   localparam logic [3:0] OLC_FMT_TRGB1666 = 4'h7;
   localparam logic [3:0] OLC_FMT_TRGB1666_PACKED = 4'h8;
   localparam logic [3:0] OLC_FMT_RGB888 = 4'h9;
   localparam logic [3:0] OLC_FMT_RGB888_PACKED = 4'hA;
   localparam logic [3:0] OLC_FMT_TRGB1888 = 4'hB;
   localparam logic [3:0] OLC_FMT_ARGB8888 = 4'hC;
   localparam logic [3:0] OLC_FMT_RGBA8888 = 4'hD;

   // palette depth codes
   localparam logic [1:0] OLC_DEPTH_1 = 2'h0;
   localparam logic [1:0] OLC_DEPTH_2 = 2'h1;
   localparam logic [1:0] OLC_DEPTH_4 = 2'h2;
   localparam logic [1:0] OLC_DEPTH_8 = 2'h3;

endpackage : olc_pkg

// [olc_pixel_expand.sv]
// widens one direct colour pixel to 24-bit rgb
`timescale 1ns/1ps
`default_nettype none
module olc_pixel_expand (
   input wire logic [3:0] format,
   input wire logic [31:0] pixel,
   input wire logic replicate,
   output logic [23:0] rgb
);

   // shift a component to the top, fill low bits with zero or its msb
   function automatic logic [7:0] widen(input logic [7:0] v, input logic [3:0] w, input logic low_bit_replicate);
      logic [7:0] s;
      logic top;
      s = v << (4'h8 - w);
      top = s[7];
      for (int i = 0; i < 8; i++)
      begin
         if (low_bit_replicate && (i < (8 - int'(w))))
            s[i] = top;
      end
      return s;
   endfunction : widen

   logic [7:0] r_raw;
   logic [7:0] g_raw;
   logic [7:0] b_raw;
   logic [3:0] r_w;
   logic [3:0] g_w;
   logic [3:0] b_w;

   // per format component extraction
   always_comb
   begin
      r_raw = 8'h00;
      g_raw = 8'h00;
      b_raw = 8'h00;
      r_w = 4'h8;
      g_w = 4'h8;
      b_w = 4'h8;
      case (format)
         olc_pkg::OLC_FMT_RGB444, olc_pkg::OLC_FMT_ARGB4444:
         begin
            r_raw = {4'h0, pixel[11:8]};
            g_raw = {4'h0, pixel[7:4]};
            b_raw = {4'h0, pixel[3:0]};
            r_w = 4'h4;
            g_w = 4'h4;
            b_w = 4'h4;
         end
         olc_pkg::OLC_FMT_RGBA4444:
         begin
            r_raw = {4'h0, pixel[15:12]};
            g_raw = {4'h0, pixel[11:8]};
            b_raw = {4'h0, pixel[7:4]};
            r_w = 4'h4;
            g_w = 4'h4;
            b_w = 4'h4;
         end
         olc_pkg::OLC_FMT_RGB565:
         begin
            r_raw = {3'h0, pixel[15:11]};
            g_raw = {2'h0, pixel[10:5]};
            b_raw = {3'h0, pixel[4:0]};
            r_w = 4'h5;
            g_w = 4'h6;
            b_w = 4'h5;
         end
         olc_pkg::OLC_FMT_TRGB1555:
         begin
            r_raw = {3'h0, pixel[14:10]};
            g_raw = {3'h0, pixel[9:5]};
            b_raw = {3'h0, pixel[4:0]};
            r_w = 4'h5;
            g_w = 4'h5;
            b_w = 4'h5;
         end
         olc_pkg::OLC_FMT_RGB666, olc_pkg::OLC_FMT_RGB666_PACKED,
         olc_pkg::OLC_FMT_TRGB1666, olc_pkg::OLC_FMT_TRGB1666_PACKED:
         begin
            r_raw = {2'h0, pixel[17:12]};
            g_raw = {2'h0, pixel[11:6]};
            b_raw = {2'h0, pixel[5:0]};
            r_w = 4'h6;
            g_w = 4'h6;
            b_w = 4'h6;
         end
         olc_pkg::OLC_FMT_RGBA8888:
         begin
            r_raw = pixel[31:24];
            g_raw = pixel[23:16];
            b_raw = pixel[15:8];
         end
         default:
         begin
            r_raw = pixel[23:16];
            g_raw = pixel[15:8];
            b_raw = pixel[7:0];
         end
      endcase
   end

   // low bit fill for depths below 24 bits
   assign rgb = {widen(r_raw, r_w, replicate), widen(g_raw, g_w, replicate), widen(b_raw, b_w, replicate)};

endmodule : olc_pixel_expand
`default_nettype wire

// [olc_fb_model.sv]
// frame buffer memory model feeding raw pixel words to the layer
`timescale 1ns/1ps
`default_nettype none
module olc_fb_model (
   input wire logic core_clk,
   input wire logic rd_req,
   input wire logic [31:0] fetch_addr,
   output logic pix_in_valid,
   output logic [31:0] pix_in_word
);
   logic [31:0] mem [16];
   // one word per request; between reads the data line flips to its inverse each cycle, so every second idle cycle repeats the last word
   initial pix_in_word = 32'h5A5A5A5A;
   always @(posedge core_clk)
   begin
      pix_in_valid <= rd_req;
      pix_in_word <= rd_req ? mem[fetch_addr[5:2]] : ~pix_in_word;
   end
endmodule : olc_fb_model
`default_nettype wire

// [tb_olc_layer_config.sv]
// self-checking bench for the overlay layer configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_olc_layer_config;
   logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic frame_start = 1'b0, pixel_advance = 1'b0, rd_req = 1'b0, clk_en = 1'b1, err;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, base_addr = 32'h0, prdata, fetch_addr, rd, pix_in_word;
   logic pready, pslverr, pix_in_valid, pix_out_valid, pix_out_key_match, fetch_busy, palette_mode;
   logic [23:0] pix_out_rgb;
   logic [5:0] bits_per_pixel;
   logic [10:0] window_left, window_top;
   logic [11:0] window_width, window_height;
   int error_cnt = 0, comparisons = 0;
   logic [31:0] masks [7] = '{32'h3F1, 32'h07FF07FF, 32'h07FF07FF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFF, 32'hFFFFFF};
   logic [5:0] bpp [14] = '{6'hC, 6'h10, 6'h10, 6'h10, 6'h10, 6'h12, 6'h12, 6'h13, 6'h13, 6'h18, 6'h18, 6'h19, 6'h20, 6'h20};

   // clock source
   always #25 core_clk = ~core_clk;

   olc_layer_config olc_layer_config_inst (.core_clk, .sys_rst, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .pix_in_valid, .pix_in_word, .pix_out_valid, .pix_out_rgb,
      .pix_out_key_match, .frame_start, .pixel_advance, .base_addr, .fetch_addr, .fetch_busy, .palette_mode,
      .bits_per_pixel, .window_left, .window_top, .window_width, .window_height);
   olc_fb_model olc_fb_model_inst (.core_clk, .rd_req, .fetch_addr, .pix_in_valid, .pix_in_word);

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer, setup then access until pready
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: no pready", $time);
         print_verdict();
      end
   endtask : apb

   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle

   // one pixel word through the model and the colour path
   task automatic pix(input logic [31:0] w, input logic [23:0] c, input logic m);
      olc_fb_model_inst.mem[0] = w;
      @(posedge core_clk);
      rd_req <= 1'b1;
      @(posedge core_clk);
      rd_req <= 1'b0;
      // result stands for one cycle after the model's valid word
      @(posedge core_clk);
      #1;
      check(32'(pix_out_valid), 32'h1);
      check(32'(pix_out_rgb), 32'(c));
      check(32'(pix_out_key_match), 32'(m));
   endtask : pix

   task automatic step(input logic [31:0] a);
      @(posedge core_clk);
      pixel_advance <= 1'b1;
      @(posedge core_clk);
      pixel_advance <= 1'b0;
      #1;
      check(fetch_addr, a);
   endtask : step

   // main sequence
   initial
   begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, 32'hF8038130 + 32'(4 * i), 32'h0);
         check(rd, 32'h0);
         apb(1'b1, 32'hF8038130 + 32'(4 * i), 32'hFFFFFFFF);
         apb(1'b0, 32'hF8038130 + 32'(4 * i), 32'h0);
         check(rd, masks[i]);
      end
      apb(1'b0, 32'hF8038154, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      $display("test registers done");
      apb(1'b1, olc_pkg::OLC_ADDR_POSITION, 32'h00230045);
      apb(1'b1, olc_pkg::OLC_ADDR_SIZE, 32'h00010001);
      settle();
      check(32'(window_left), 32'h45);
      check(32'(window_top), 32'h23);
      check(32'(window_width), 32'h2);
      check(32'(window_height), 32'h2);
      $display("test geometry done");
      for (int c = 0; c < 14; c++)
      begin
         apb(1'b1, olc_pkg::OLC_ADDR_FORMAT, 32'(c) << 4);
         settle();
         check(32'(bits_per_pixel), 32'(bpp[c]));
         check(32'(palette_mode), 32'h0);
      end
      for (int d = 0; d < 4; d++)
      begin
         apb(1'b1, olc_pkg::OLC_ADDR_FORMAT, (32'(d) << 8) | 32'h1);
         settle();
         check(32'(bits_per_pixel), 32'h1 << d);
         check(32'(palette_mode), 32'h1);
      end
      $display("test formats done");
      apb(1'b1, olc_pkg::OLC_ADDR_DEFAULT, 32'h00A1B2C3);
      apb(1'b1, olc_pkg::OLC_ADDR_KEY, 32'h00A1B2C2);
      apb(1'b1, olc_pkg::OLC_ADDR_KEY_MASK, 32'h00FFFFFE);
      apb(1'b1, olc_pkg::OLC_ADDR_BLEND, 32'h1);
      pix(32'h0, 24'hA1B2C3, 1'b1);
      apb(1'b1, olc_pkg::OLC_ADDR_BLEND, 32'h0);
      pix(32'h0, 24'hA1B2C3, 1'b0);
      apb(1'b1, olc_pkg::OLC_ADDR_BLEND, 32'h1);
      apb(1'b1, olc_pkg::OLC_ADDR_KEY_MASK, 32'h00FFFFFF);
      pix(32'h0, 24'hA1B2C3, 1'b0);
      apb(1'b1, olc_pkg::OLC_ADDR_KEY_MASK, 32'h0);
      pix(32'h0, 24'hA1B2C3, 1'b1);
      apb(1'b1, olc_pkg::OLC_ADDR_PAL_INDEX, 32'h0);
      apb(1'b1, olc_pkg::OLC_ADDR_PAL_DATA, 32'h00ABCDEF);
      apb(1'b1, olc_pkg::OLC_ADDR_BLEND, 32'h100);
      pix(32'h100, 24'hABCDEF, 1'b0);
      apb(1'b1, olc_pkg::OLC_ADDR_FORMAT, 32'h90);
      pix(32'h00123456, 24'h123456, 1'b0);
      apb(1'b1, olc_pkg::OLC_ADDR_FORMAT, 32'h30);
      pix(32'h8000, 24'h800000, 1'b0);
      apb(1'b1, olc_pkg::OLC_ADDR_BLEND, 32'h300);
      pix(32'h8000, 24'h870000, 1'b0);
      $display("test colour done");
      apb(1'b1, olc_pkg::OLC_ADDR_ROW_STRIDE, 32'h100);
      apb(1'b1, olc_pkg::OLC_ADDR_PIX_STRIDE, 32'h4);
      @(posedge core_clk);
      frame_start <= 1'b1;
      base_addr <= 32'h1000;
      @(posedge core_clk);
      frame_start <= 1'b0;
      #1;
      check(32'(fetch_busy), 32'h1);
      check(fetch_addr, 32'h1000);
      step(32'h1004);
      step(32'h1100);
      // clock enable low freezes the walker
      @(posedge core_clk);
      clk_en <= 1'b0;
      step(32'h1100);
      @(posedge core_clk);
      clk_en <= 1'b1;
      step(32'h1104);
      $display("test walker done");
      print_verdict();
   end
endmodule : tb_olc_layer_config
`default_nettype wire
